/* File: sdbc_block_config.v */
// sdram block configuration: control, mask, global registers, hit decode,
// refresh pacer and initiate-command sequencing
// assumes an apb master on clk_i and a sdram sequencer fed by the outputs
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "sdbc_regs.vh"
module sdbc_block_config (
    input wire clk_i,
    input wire nrst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire acc_valid_i,
    input wire acc_write_i,
    input wire [31:0] acc_addr_i,
    input wire refresh_done_i,
    output reg acc_hit_o,
    output reg acc_err_o,
    output reg [2:0] sd_cmd_o,
    output reg [12:0] sd_addr_o,
    output reg [1:0] sd_bank_o,
    output reg [1:0] column_latency_o,
    output reg refresh_req_o
);
// ----------------------------------------
// commands on sd_cmd_o
// ----------------------------------------
localparam CMD_NONE = 3'h0;
localparam CMD_ACCESS = 3'h1;
localparam CMD_PALL = 3'h2;
localparam CMD_MRS = 3'h3;
reg [31:0] ctrl_reg;
reg [31:0] mask_reg;
reg [31:0] gctl_reg;
reg [3:0] ref_seen_reg;
reg [`SDBC_CNT_W-1:0] ref_cnt_reg;
wire wr_en;
wire rd_en;
wire hit;
wire [13:0] base_cmp;
wire [`SDBC_CNT_W-1:0] ref_period;
wire mode_set_initiate_done;
wire ip_done;
reg [31:0] rd_mux;
reg map_err;
assign wr_en = psel_i & penable_i & pwrite_i;
// read data latched in the setup cycle so it stands while pready is high
assign rd_en = psel_i & ~penable_i & ~pwrite_i;
// ----------------------------------------
// hit decode
// ----------------------------------------
assign base_cmp = (acc_addr_i[`SDBC_BASE_HI:`SDBC_BASE_LO] ^ ctrl_reg[`SDBC_BASE_HI:`SDBC_BASE_LO])
    & ~mask_reg[`SDBC_BASE_HI:`SDBC_BASE_LO];
assign hit = acc_valid_i & mask_reg[`SDBC_V_BIT] & (base_cmp == 14'h0000);
assign mode_set_initiate_done = hit & ctrl_reg[`SDBC_MODE_SET_INITIATE_BIT];
assign ip_done = hit & ~ctrl_reg[`SDBC_MODE_SET_INITIATE_BIT] & ctrl_reg[`SDBC_IP_BIT];
// ----------------------------------------
// register read mux
// ----------------------------------------
always @* begin
    rd_mux = `SDBC_ZERO32;
    map_err = 1'b0;
    case (paddr_i)
        `SDBC_ADDR_CTRL: rd_mux = ctrl_reg;
        `SDBC_ADDR_MASK: rd_mux = mask_reg;
        `SDBC_ADDR_GCTL: rd_mux = gctl_reg;
        `SDBC_ADDR_STAT: rd_mux = {28'h0000000, ref_seen_reg};
        default: map_err = 1'b1;
    endcase
end
// ----------------------------------------
// apb slave and registers
// ----------------------------------------
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        ctrl_reg <= `SDBC_ZERO32;
        mask_reg <= `SDBC_ZERO32;
        gctl_reg <= `SDBC_ZERO32;
        prdata_o <= `SDBC_ZERO32;
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
    end else begin
        pready_o <= psel_i & ~penable_i;
        pslverr_o <= psel_i & ~penable_i & map_err;
        if (rd_en) begin
            prdata_o <= rd_mux;
        end
        if (wr_en && pready_o && paddr_i == `SDBC_ADDR_CTRL) begin
            ctrl_reg <= pwdata_i & `SDBC_CTRL_WMASK;
        end else begin
            // initiate bits self-clear once the block access has used them
            if (mode_set_initiate_done) begin
                ctrl_reg[`SDBC_MODE_SET_INITIATE_BIT] <= 1'b0;
            end
            if (ip_done) begin
                ctrl_reg[`SDBC_IP_BIT] <= 1'b0;
            end
        end
        if (wr_en && pready_o && paddr_i == `SDBC_ADDR_MASK) begin
            mask_reg <= pwdata_i & `SDBC_MASK_WMASK;
        end
        if (wr_en && pready_o && paddr_i == `SDBC_ADDR_GCTL) begin
            gctl_reg <= pwdata_i & `SDBC_GCTL_WMASK;
        end
    end
end
// ----------------------------------------
// refresh pacer
// ----------------------------------------
// count widened by one bit so the largest count plus one does not wrap
assign ref_period = {{1'b0, gctl_reg[`SDBC_RC_HI:`SDBC_RC_LO]} + 10'h001, 4'h0};
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        ref_cnt_reg <= `SDBC_CNT_ONE;
        refresh_req_o <= 1'b0;
        ref_seen_reg <= 4'h0;
    end else begin
        refresh_req_o <= 1'b0;
        if (!ctrl_reg[`SDBC_RE_BIT]) begin
            ref_cnt_reg <= `SDBC_CNT_ONE;
            ref_seen_reg <= 4'h0;
        end else begin
            if (ref_cnt_reg >= ref_period) begin
                ref_cnt_reg <= `SDBC_CNT_ONE;
                refresh_req_o <= 1'b1;
            end else begin
                ref_cnt_reg <= ref_cnt_reg + `SDBC_CNT_ONE;
            end
            if (refresh_done_i && ref_seen_reg != 4'hf) begin
                ref_seen_reg <= ref_seen_reg + 4'h1;
            end
        end
    end
end
// ----------------------------------------
// command and address to the sdram sequencer
// ----------------------------------------
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        acc_hit_o <= 1'b0;
        acc_err_o <= 1'b0;
        sd_cmd_o <= CMD_NONE;
        sd_addr_o <= 13'h0000;
        sd_bank_o <= 2'h0;
        column_latency_o <= `SDBC_COLUMN_LATENCY_FIELD_1;
    end else begin
        column_latency_o <= ctrl_reg[`SDBC_COLUMN_LATENCY_FIELD_HI:`SDBC_COLUMN_LATENCY_FIELD_LO];
        acc_hit_o <= hit;
        acc_err_o <= hit & acc_write_i & mask_reg[`SDBC_WP_BIT];
        sd_cmd_o <= CMD_NONE;
        sd_addr_o <= 13'h0000;
        sd_bank_o <= 2'h0;
        if (hit && ctrl_reg[`SDBC_MODE_SET_INITIATE_BIT]) begin
            sd_cmd_o <= CMD_MRS;
            // unmultiplexed: a[10:0] straight from the mapped address lines
            sd_addr_o <= {2'h0, acc_addr_i[20:17], acc_addr_i[9], acc_addr_i[10],
                acc_addr_i[11], acc_addr_i[12], acc_addr_i[13], acc_addr_i[14],
                acc_addr_i[15]};
            sd_bank_o <= acc_addr_i[22:21];
        end else if (hit && ctrl_reg[`SDBC_IP_BIT]) begin
            sd_cmd_o <= CMD_PALL;
            sd_addr_o <= 13'h0400;
        end else if (hit && !(acc_write_i && mask_reg[`SDBC_WP_BIT])) begin
            sd_cmd_o <= CMD_ACCESS;
            sd_addr_o <= {2'h0, acc_addr_i[20:17], acc_addr_i[9], acc_addr_i[10],
                acc_addr_i[11], acc_addr_i[12], acc_addr_i[13], acc_addr_i[14],
                acc_addr_i[15]};
            if (ctrl_reg[`SDBC_CBM_HI:`SDBC_CBM_LO] == `SDBC_CBM_A20) begin
                sd_bank_o <= acc_addr_i[22:21];
            end else begin
                sd_bank_o <= acc_addr_i[24:23];
            end
        end
    end
end
endmodule // sdbc_block_config

/* File: sdbc_regs.vh */
// constants for the sdram block configuration logic
// assumes an apb slave with 32-bit data and a 50 MHz bus clock
// Operation
// - access hits when upper bits match base
// - no refresh while refresh enable clear
// - latency 00 means data one cycle later
// - mapping 011 puts command on line 20
// - mode set initiate turns next access into mode set
// - precharge initiate reads zero when not requested
// - set mask bits are excluded from hit
// - write protect clear allows reads and writes
// - mode value on sdram a[10:0] first cycle
// - address not multiplexed during mode set
// - refresh spacing is (count plus one) times 16
`ifndef SDBC_REGS_VH
`define SDBC_REGS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SDBC_ADDR_CTRL 12'h000
`define SDBC_ADDR_MASK 12'h004
`define SDBC_ADDR_GCTL 12'h008
`define SDBC_ADDR_STAT 12'h00c
// ----------------------------------------
// field positions
// ----------------------------------------
`define SDBC_BASE_HI 31
`define SDBC_BASE_LO 18
`define SDBC_RE_BIT 15
`define SDBC_COLUMN_LATENCY_FIELD_HI 13
`define SDBC_COLUMN_LATENCY_FIELD_LO 12
`define SDBC_CBM_HI 10
`define SDBC_CBM_LO 8
`define SDBC_MODE_SET_INITIATE_BIT 6
`define SDBC_PS_HI 5
`define SDBC_PS_LO 4
`define SDBC_IP_BIT 3
`define SDBC_WP_BIT 8
`define SDBC_V_BIT 0
`define SDBC_RC_HI 8
`define SDBC_RC_LO 0
// ----------------------------------------
// writable bit masks and values
// ----------------------------------------
`define SDBC_CTRL_WMASK 32'hfffcb778
`define SDBC_MASK_WMASK 32'hfffc0101
`define SDBC_GCTL_WMASK 32'h000001ff
`define SDBC_ZERO32 32'h00000000
`define SDBC_COLUMN_LATENCY_FIELD_1 2'h0
`define SDBC_CBM_A20 3'h3
`define SDBC_REF_MUL 4
`define SDBC_CNT_W 14
`define SDBC_CNT_ONE 14'h0001
`define SDBC_CNT_ZERO 14'h0000
`define SDBC_CMD_W 3
`endif

/* File: sdbc_chk_sva.sv */
// port checker for sdbc_block_config
// assumes one-cycle apb access; shadows rebuilt from apb writes
`timescale 1ns/1ps
module sdbc_chk (input logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, acc_valid_i,
    input logic acc_hit_o, acc_err_o, refresh_req_o, input logic [11:0] paddr_i,
    input logic [31:0] pwdata_i, acc_addr_i, input logic [2:0] sd_cmd_o,
    input logic [12:0] sd_addr_o, input logic [1:0] sd_bank_o, column_latency_o);
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
// ----------------------------------------
// shadow registers and refresh gap counter
// ----------------------------------------
logic [31:0] ctl_reg, msk_reg;
logic [8:0] rc_reg;
logic [13:0] cnt_reg;
logic arm_reg;
wire wr = psel_i && penable_i && pready_o && pwrite_i;
wire hit = msk_reg[0] && ((acc_addr_i[31:18] ^ ctl_reg[31:18]) & ~msk_reg[31:18]) == 14'h0000;
wire go = acc_valid_i && hit;
wire [10:0] mode = {acc_addr_i[20:17], acc_addr_i[9], acc_addr_i[10], acc_addr_i[11], acc_addr_i[12],
    acc_addr_i[13], acc_addr_i[14], acc_addr_i[15]};
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        ctl_reg <= 32'h0;
        msk_reg <= 32'h0;
        rc_reg <= 9'h000;
        cnt_reg <= 14'h0000;
        arm_reg <= 1'b0;
    end else begin
        // initiate bits clear on the hitting access; a write in that cycle wins
        if (go && ctl_reg[6]) ctl_reg[6] <= 1'b0;
        else if (go && ctl_reg[3]) ctl_reg[3] <= 1'b0;
        if (wr && paddr_i == 12'h000) ctl_reg <= pwdata_i;
        if (wr && paddr_i == 12'h004) msk_reg <= pwdata_i;
        if (wr && paddr_i == 12'h008) rc_reg <= pwdata_i[8:0];
        cnt_reg <= refresh_req_o ? 14'h0001 : cnt_reg + 14'h0001;
        arm_reg <= wr ? 1'b0 : (refresh_req_o | arm_reg);
    end
end
a_hit_match: assert property (go |=> acc_hit_o) else $error("hit missing");
a_miss_quiet: assert property (acc_valid_i && !hit |=> !acc_hit_o && sd_cmd_o == 3'h0) else $error("false hit");
a_refresh_off: assert property (!ctl_reg[15] && !$past(ctl_reg[15]) |-> !refresh_req_o) else $error("refresh off");
a_latency_copy: assert property (column_latency_o == $past(ctl_reg[13:12])) else $error("latency wrong");
a_bank_upper: assert property (go && ctl_reg[10:8] == 3'h3 && !ctl_reg[6] && !ctl_reg[3] && !msk_reg[8]
    |=> sd_cmd_o == 3'h1 && sd_bank_o == $past(acc_addr_i[22:21])) else $error("bank wrong");
a_mode_value: assert property (go && ctl_reg[6] |=> sd_cmd_o == 3'h3 && sd_addr_o[10:0] == $past(mode))
    else $error("mode set wrong");
a_precharge_cmd: assert property (go && ctl_reg[3] && !ctl_reg[6] |=> sd_cmd_o == 3'h2) else $error("no precharge");
a_wp_open: assert property (go && !msk_reg[8] |=> acc_hit_o && !acc_err_o) else $error("access refused");
a_refresh_gap: assert property (refresh_req_o && arm_reg |-> cnt_reg == {1'b0, rc_reg, 4'h0} + 14'h0010)
    else $error("refresh gap wrong");
c_mode: cover property (go && ctl_reg[6]);
c_gap: cover property (refresh_req_o && arm_reg);
c_miss: cover property (acc_valid_i && !hit);
endmodule // sdbc_chk

/* File: sdbc_sdram_mdl.sv */
// sdram component model: answers refreshes, counts mode sets
// assumes one-cycle command pulses from the block
`timescale 1ns/1ps
module sdbc_sdram_mdl (input logic clk_i, nrst_i, refresh_req_i, input logic [2:0] cmd_i,
    output logic refresh_done_o);
logic [2:0] busy_reg;
int mode_sets;
assign refresh_done_o = busy_reg[2];
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        busy_reg <= 3'h0;
        mode_sets <= 0;
    end else begin
        busy_reg <= {busy_reg[1:0], refresh_req_i};
        if (cmd_i == 3'h3) mode_sets <= mode_sets + 1;
    end
end
endmodule // sdbc_sdram_mdl

/* File: tb_top.sv */
// self-checking bench for sdbc_block_config
// assumes the sdram model and the bound checker beside it
`timescale 1ns/1ps
module tb_top;
logic clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, acc_valid_i = 0, acc_write_i = 0;
logic [11:0] paddr_i = 12'h000;
logic [31:0] pwdata_i = 32'h0, acc_addr_i = 32'h0, prdata_o, q;
logic pready_o, pslverr_o, acc_hit_o, acc_err_o, refresh_done_i, refresh_req_o, err_s;
logic [2:0] sd_cmd_o;
logic [12:0] sd_addr_o;
logic [1:0] sd_bank_o, column_latency_o;
int miscompares = 0, check_count = 0;
sdbc_block_config u_dut (.*);
sdbc_sdram_mdl u_mem (.clk_i(clk_i), .nrst_i(nrst_i), .refresh_req_i(refresh_req_o), .cmd_i(sd_cmd_o),
    .refresh_done_o(refresh_done_i));
always #10 clk_i = ~clk_i;
// ----------------------------------------
// bus and access tasks
// ----------------------------------------
task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
        @(posedge clk_i);
        n++;
    end while (pready_o !== 1'b1 && n < 50);
    // response taken at the edge where pready is sampled high
    err_s = pslverr_o;
    q = prdata_o;
    if (pready_o !== 1'b1) miscompares++;
    psel_i <= 1'b0; penable_i <= 1'b0;
endtask
task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
endtask
task acc(input logic [31:0] a, input logic w);
    @(posedge clk_i);
    acc_valid_i <= 1'b1; acc_write_i <= w; acc_addr_i <= a;
    @(posedge clk_i);
    acc_valid_i <= 1'b0;
    #1;
endtask
task end_of_test;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask
initial begin
    repeat (3000) @(posedge clk_i);
    miscompares++;
    end_of_test;
end
initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h010, 32'h0);
    chk(err_s, 1'b1);
    $display("test reset done");
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h004, 32'h00740001);
    apb(1'b1, 12'h000, 32'hff880308);
    acc(32'hff880000, 1'b1);
    chk(sd_cmd_o, 3'h2);
    rd(12'h000, 32'hff880300);
    chk(column_latency_o, 2'h0);
    $display("test precharge done");
    apb(1'b1, 12'h000, 32'hff888300);
    repeat (270) @(posedge clk_i);
    rd(12'h00c, 32'h8);
    apb(1'b1, 12'h004, 32'h00680001);
    apb(1'b1, 12'h000, 32'hff888340);
    acc(32'hff800800, 1'b0);
    chk({sd_cmd_o, sd_addr_o[10:0]}, 14'h1810);
    rd(12'h000, 32'hff888300);
    chk(u_mem.mode_sets, 1);
    $display("test mode set done");
    apb(1'b1, 12'h000, 32'hff888300);
    apb(1'b1, 12'h004, 32'h00740001);
    acc(32'hffe80000, 1'b1);
    chk({acc_hit_o, acc_err_o, sd_cmd_o, sd_bank_o}, 7'h47);
    acc(32'hff800000, 1'b1);
    chk(acc_hit_o, 1'b0);
    apb(1'b1, 12'h004, 32'h00740000);
    acc(32'hff880000, 1'b1);
    chk(acc_hit_o, 1'b0);
    apb(1'b1, 12'h000, 32'hff880300);
    repeat (80) @(posedge clk_i);
    rd(12'h00c, 32'h0);
    $display("test decode done");
    end_of_test;
end
endmodule // tb_top
bind sdbc_block_config sdbc_chk u_chk (.*);
